// ==== src/coupling_pkg.sv ====
// Purpose: Shared constants and types for the multi-unit coupling block
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: Command codes are the fast numeric codes of the coupling commands

package coupling_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [7:0] OFS_ARG0 = 8'h00;
   localparam logic [7:0] OFS_ARG1 = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_RESP = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // Command word: code in the low bits, query flag at the top
   localparam int CMD_QUERY_BIT = 31;
   localparam int CMD_CODE_W = 20;

   localparam logic [19:0] CODE_ROLE = 20'h0002A;
   localparam logic [19:0] CODE_DELAY = 20'h0003A;
   localparam logic [19:0] CODE_COUPLE = 20'h0006A;
   localparam logic [19:0] CODE_PATH = 20'h0191A;
   localparam logic [19:0] CODE_LINE = 20'h0210A;
   localparam logic [19:0] CODE_LIST_DEL = 20'h00040;
   localparam logic [19:0] CODE_LIST_INS = 20'h00051;
   localparam logic [19:0] CODE_BYPASS = 20'h0203A;

   // Status register bits
   localparam int ST_ERR_BIT = 0;
   localparam int ST_COUPLE_BIT = 1;
   localparam int ST_DELAY_BIT = 2;
   localparam int ST_RATE_BIT = 3;
   localparam int ST_LAN_BIT = 4;
   localparam int ST_FOLLOW_BIT = 5;

   // Start delay: seconds in fixed point, 16 fraction bits, 0 to 20 s
   localparam int DELAY_W = 21;
   localparam logic [20:0] DELAY_MAX = 21'h140000;
   localparam logic [20:0] DELAY_RST = 21'h000000;
   localparam int CLK_HZ = 32'h0BEBC200;
   localparam int DELAY_LSB_PER_S = 32'h00010000;
   localparam int TICK_CYCLES = CLK_HZ / DELAY_LSB_PER_S;
   localparam int TICK_W = 12;

   typedef enum logic [1:0] {
      PATH_NEIGHBOUR = 2'b00,
      PATH_ECL = 2'b01,
      PATH_LBUS = 2'b10
   } path_t;

   localparam path_t PATH_RST = PATH_NEIGHBOUR;
   localparam logic COUPLE_RST = 1'b0;
   localparam logic ROLE_RST = 1'b0;
   localparam logic [1:0] LINE_RST = 2'b00;

   // Follower list for LAN operation
   localparam int LIST_DEPTH = 8;
   localparam logic [7:0] DESIG_BASE = 8'h02;

   // Synchronised pin inputs
   localparam int SYNC_W = 6;
   localparam int SI_ECL0 = 0;
   localparam int SI_ECL1 = 1;
   localparam int SI_NEIGH = 2;
   localparam int SI_LBUS = 3;
   localparam int SI_COMBO = 4;
   localparam int SI_LAN = 5;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_DELAY = 1'b1
   } start_st_t;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

endpackage

// ==== src/sync_if.sv ====
// Purpose: Carries raw pins to the synchroniser and clean levels back
// Assumes: One clock domain on the user side
// Notes: rise is a one-cycle pulse

`timescale 1ns/10ps
`default_nettype none

interface sync_if;
   import coupling_pkg::*;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] level;
   logic [SYNC_W-1:0] rise;
   modport sync_side(input raw, output level, output rise);
   modport user_side(output raw, input level, input rise);
endinterface

`default_nettype wire

// ==== src/sync_edge.sv ====
// Purpose: Two-flop synchroniser with rising edge detect per input
// Assumes: Inputs are asynchronous to aclk
// Notes: Only the second flop and later feed logic

`timescale 1ns/10ps
`default_nettype none

module sync_edge
   import coupling_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pin side and user side
   sync_if.sync_side s
);

   logic [SYNC_W-1:0] meta_r, meta_nxt;
   logic [SYNC_W-1:0] stab_r, stab_nxt;
   logic [SYNC_W-1:0] prev_r, prev_nxt;
   logic [SYNC_W-1:0] rise_r, rise_nxt;

   always_comb begin
      meta_nxt = s.raw;
      stab_nxt = meta_r;
      prev_nxt = stab_r;
      rise_nxt = stab_r & ~prev_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         stab_r <= '0;
         prev_r <= '0;
         rise_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         stab_r <= stab_nxt;
         prev_r <= prev_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign s.level = stab_r;
   assign s.rise = rise_r;

endmodule

`default_nettype wire

// ==== src/multi_unit_sync_coupling.sv ====
// Purpose: Command-driven start coupling between generator units
// Assumes: Commands arrive as code plus arguments over AXI4-Lite
// Notes: Writing CMD executes the command; RESP holds any answer
//
// How it works
// - Follower start delayed 0..20 s, default zero
// - Unit one leads; followers are delayed
// - Delay only in continuous, synchronised operation
// - Delay query returns programmed seconds
// - Path select: neighbour, ECL lines, local bus
// - Neighbour path only for supported carrier combos
// - ECL path enables lines; clock under 66 MHz
// - Path query reports selected path
// - Delete follower by IP, LAN only
// - Insert follower and assign designator, LAN only
// - Coupling on or off, default off
// - Coupling query returns one or zero
// - Legacy output bypass command raises error
// - Trigger lines 0 and 1 become sync outputs
// - Each line output off after reset
// - Line query answers line then state
//
// Our own choices: the register offsets and register access over AXI4-Lite.

`timescale 1ns/10ps
`default_nettype none

module multi_unit_sync_coupling
   import coupling_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES
)(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Waveform engine
   input wire logic start_req,
   input wire logic continuous_mode,
   input wire logic ref_clk_lvl,
   input wire logic rate_above_66m,
   output logic wave_start,
   output logic link_clk_tick,
   // Backplane and carrier pins
   input wire logic [1:0] ecl_in,
   output logic [1:0] ecl_out,
   output logic [1:0] ecl_oe,
   input wire logic neighbour_in,
   output logic neighbour_out,
   output logic neighbour_oe,
   input wire logic lbus_in,
   output logic lbus_out,
   output logic lbus_oe,
   input wire logic carrier_combo_ok,
   input wire logic lan_mode
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   sync_if pins ();
   assign pins.raw = {lan_mode, carrier_combo_ok, lbus_in, neighbour_in,
                      ecl_in};
   sync_edge u_sync (.aclk(aclk), .aresetn(aresetn), .s(pins.sync_side));

   ////////////////////////////////////////////////////////////////////////
   // State
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, arg0_r, arg0_nxt, arg1_r, arg1_nxt;
   logic [31:0] resp_r, resp_nxt;
   logic role_r, role_nxt, couple_r, couple_nxt, err_r, err_nxt;
   logic [DELAY_W-1:0] delay_r, delay_nxt, remain_r, remain_nxt;
   path_t path_r, path_nxt;
   logic [1:0] line_r, line_nxt, ecl_out_r, ecl_out_nxt;
   logic [LIST_DEPTH-1:0] lvalid_r, lvalid_nxt;
   logic [31:0] lip_r [LIST_DEPTH];
   logic [31:0] lip_nxt [LIST_DEPTH];
   logic [31:0] lmodel_r [LIST_DEPTH];
   logic [31:0] lmodel_nxt [LIST_DEPTH];
   start_st_t st_r, st_nxt;
   logic [TICK_W-1:0] tick_r, tick_nxt;
   logic wave_r, wave_nxt, nb_out_r, nb_out_nxt, lb_out_r, lb_out_nxt;

   logic wr_fire, cmd_go, query, err_set, err_clr, lan_ok;
   logic [31:0] wword;
   logic [19:0] code;
   logic [7:0] line_sel;
   logic hit_found, free_found;
   logic [2:0] hit_idx, free_idx;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   assign wr_fire = awvalid && wvalid && !bvalid_r;
   assign awready = wr_fire;
   assign wready = wr_fire;
   assign arready = !rvalid_r;
   assign wword = merge_bytes(32'h00000000, wdata, wstrb);
   assign cmd_go = wr_fire && awaddr == OFS_CMD;
   assign code = wword[CMD_CODE_W-1:0];
   assign query = wword[CMD_QUERY_BIT];
   assign err_clr = wr_fire && awaddr == OFS_STATUS && wword[ST_ERR_BIT];
   assign lan_ok = pins.level[SI_LAN];
   assign line_sel = arg0_r[15:8];

   always_comb begin
      bvalid_nxt = bvalid_r && !bready;
      bresp_nxt = bresp_r;
      arg0_nxt = arg0_r;
      arg1_nxt = arg1_r;
      if (wr_fire) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OKAY;
         case (awaddr)
            OFS_ARG0: arg0_nxt = merge_bytes(arg0_r, wdata, wstrb);
            OFS_ARG1: arg1_nxt = merge_bytes(arg1_r, wdata, wstrb);
            OFS_CMD, OFS_STATUS: bresp_nxt = RESP_OKAY;
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      rvalid_nxt = rvalid_r && !rready;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OKAY;
         case (araddr)
            OFS_ARG0: rdata_nxt = arg0_r;
            OFS_ARG1: rdata_nxt = arg1_r;
            OFS_CMD: rdata_nxt = 32'h00000000;
            OFS_RESP: rdata_nxt = resp_r;
            OFS_STATUS: rdata_nxt = {26'h0000000, role_r, lan_ok,
               rate_above_66m && path_r == PATH_ECL,
               st_r == ST_DELAY, couple_r, err_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Follower list search
   always_comb begin
      hit_found = 1'b0;
      hit_idx = 3'h0;
      free_found = 1'b0;
      free_idx = 3'h0;
      for (int i = LIST_DEPTH - 1; i >= 0; i--) begin
         if (lvalid_r[i] && lip_r[i] == arg0_r) begin
            hit_found = 1'b1;
            hit_idx = 3'(i);
         end
         if (!lvalid_r[i]) begin
            free_found = 1'b1;
            free_idx = 3'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command interpreter
   always_comb begin
      role_nxt = role_r;
      delay_nxt = delay_r;
      couple_nxt = couple_r;
      path_nxt = path_r;
      line_nxt = line_r;
      resp_nxt = resp_r;
      lvalid_nxt = lvalid_r;
      lip_nxt = lip_r;
      lmodel_nxt = lmodel_r;
      err_set = 1'b0;
      if (cmd_go) begin
         case (code)
            CODE_ROLE: begin
               if (query) resp_nxt = {31'h00000000, role_r};
               else if (arg0_r > 32'h1) err_set = 1'b1;
               else role_nxt = arg0_r[0];
            end
            CODE_DELAY: begin
               if (query) resp_nxt = {11'h000, delay_r};
               else if (arg0_r > {11'h000, DELAY_MAX}) err_set = 1'b1;
               else delay_nxt = arg0_r[DELAY_W-1:0];
            end
            CODE_COUPLE: begin
               if (query) resp_nxt = {31'h00000000, couple_r};
               else if (arg0_r > 32'h1) err_set = 1'b1;
               else couple_nxt = arg0_r[0];
            end
            CODE_PATH: begin
               if (query) resp_nxt = {30'h00000000, path_r};
               else if (arg0_r > 32'h2) err_set = 1'b1;
               else path_nxt = path_t'(arg0_r[1:0]);
            end
            CODE_LINE: begin
               if (line_sel > 8'h01) err_set = 1'b1;
               else if (query)
                  resp_nxt = {16'h0000, line_sel, 7'h00, line_r[line_sel[0]]};
               else if (arg0_r[7:0] > 8'h01) err_set = 1'b1;
               else line_nxt[line_sel[0]] = arg0_r[0];
            end
            CODE_LIST_DEL: begin
               if (!lan_ok || query || !hit_found) err_set = 1'b1;
               else lvalid_nxt[hit_idx] = 1'b0;
            end
            CODE_LIST_INS: begin
               if (!lan_ok || query || !free_found) err_set = 1'b1;
               else begin
                  lvalid_nxt[free_idx] = 1'b1;
                  lip_nxt[free_idx] = arg0_r;
                  lmodel_nxt[free_idx] = arg1_r;
                  resp_nxt = {24'h000000, DESIG_BASE + 8'(free_idx)};
               end
            end
            default: err_set = 1'b1;
         endcase
      end
      err_nxt = err_set || (err_r && !err_clr);
   end

   ////////////////////////////////////////////////////////////////////////
   // Start coupling
   logic follow_start, delay_on, tick;
   assign tick = tick_r == TICK_W'(TICK_CNT - 1);
   always_comb begin
      case (path_r)
         PATH_ECL: follow_start = pins.rise[SI_ECL1];
         PATH_LBUS: follow_start = pins.rise[SI_LBUS];
         default: follow_start = pins.rise[SI_NEIGH];
      endcase
   end
   assign delay_on = role_r && continuous_mode &&
                     delay_r != DELAY_RST;

   always_comb begin
      st_nxt = st_r;
      remain_nxt = remain_r;
      tick_nxt = tick ? '0 : tick_r + 1'b1;
      wave_nxt = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (!role_r) wave_nxt = start_req;
            else if (follow_start && delay_on) begin
               st_nxt = ST_DELAY;
               remain_nxt = delay_r;
               tick_nxt = '0;
            end else wave_nxt = follow_start;
         end
         ST_DELAY: begin
            if (tick) begin
               remain_nxt = remain_r - 1'b1;
               if (remain_r == 21'h000001) begin
                  st_nxt = ST_IDLE;
                  wave_nxt = 1'b1;
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   logic drive_lead;
   assign drive_lead = !role_r && couple_r;
   always_comb begin
      ecl_out_nxt = {start_req, ref_clk_lvl};
      nb_out_nxt = start_req;
      lb_out_nxt = start_req;
   end
   assign ecl_oe = line_r | {2{drive_lead && path_r == PATH_ECL}};
   assign neighbour_oe = drive_lead && path_r == PATH_NEIGHBOUR &&
                         pins.level[SI_COMBO];
   assign lbus_oe = drive_lead && path_r == PATH_LBUS;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h00000000;
         arg0_r <= 32'h00000000;
         arg1_r <= 32'h00000000;
         resp_r <= 32'h00000000;
         role_r <= ROLE_RST;
         delay_r <= DELAY_RST;
         couple_r <= COUPLE_RST;
         path_r <= PATH_RST;
         line_r <= LINE_RST;
         err_r <= 1'b0;
         lvalid_r <= '0;
         lip_r <= '{default: 32'h00000000};
         lmodel_r <= '{default: 32'h00000000};
         st_r <= ST_IDLE;
         remain_r <= DELAY_RST;
         tick_r <= '0;
         wave_r <= 1'b0;
         ecl_out_r <= 2'b00;
         nb_out_r <= 1'b0;
         lb_out_r <= 1'b0;
      end else begin
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         arg0_r <= arg0_nxt;
         arg1_r <= arg1_nxt;
         resp_r <= resp_nxt;
         role_r <= role_nxt;
         delay_r <= delay_nxt;
         couple_r <= couple_nxt;
         path_r <= path_nxt;
         line_r <= line_nxt;
         err_r <= err_nxt;
         lvalid_r <= lvalid_nxt;
         lip_r <= lip_nxt;
         lmodel_r <= lmodel_nxt;
         st_r <= st_nxt;
         remain_r <= remain_nxt;
         tick_r <= tick_nxt;
         wave_r <= wave_nxt;
         ecl_out_r <= ecl_out_nxt;
         nb_out_r <= nb_out_nxt;
         lb_out_r <= lb_out_nxt;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign wave_start = wave_r;
   assign ecl_out = ecl_out_r;
   assign neighbour_out = nb_out_r;
   assign lbus_out = lb_out_r;
   assign link_clk_tick = pins.rise[SI_ECL0];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_set(logic [19:0] c);
      cmd_go && code == c && !query;
   endsequence
   sequence s_ask(logic [19:0] c);
      cmd_go && code == c && query;
   endsequence

   a_delay_store: assert property (s_set(CODE_DELAY) ##0
      arg0_r <= {11'h000, DELAY_MAX} |=> delay_r == $past(arg0_r[20:0]))
      else $error("delay setting not stored");
   a_lead_start: assert property (st_r == ST_IDLE && !role_r && start_req
      |=> wave_start ##1 !wave_start)
      else $error("lead unit start not passed through");
   a_delay_gate: assert property (st_r == ST_IDLE && role_r &&
      follow_start && !delay_on |=> wave_start && st_r == ST_IDLE)
      else $error("undelayed follower start not immediate");
   a_delay_query: assert property (s_ask(CODE_DELAY)
      |=> resp_r == {11'h000, $past(delay_r)})
      else $error("delay query answer wrong");
   a_path_reject: assert property (s_set(CODE_PATH) ##0
      arg0_r > 32'h2 |=> $stable(path_r) && err_r)
      else $error("bad path accepted");
   a_ecl_enable: assert property (path_r == PATH_ECL && drive_lead
      |-> ecl_oe == 2'b11)
      else $error("ECL lines not enabled on ECL path");
   a_couple_query: assert property (s_ask(CODE_COUPLE)
      |=> resp_r == {31'h00000000, $past(couple_r)} && $stable(couple_r))
      else $error("coupling query wrong");
   a_bypass_err: assert property (cmd_go && code == CODE_BYPASS
      |=> err_r)
      else $error("legacy bypass command not rejected");
   a_line_query: assert property (s_ask(CODE_LINE) ##0
      line_sel < 8'h02 |=> resp_r[15:8] == $past(line_sel) &&
      resp_r[0] == $past(line_r[line_sel[0]]))
      else $error("line query answer wrong");
   a_query_still: assert property (cmd_go && query |=>
      $stable(path_r) && $stable(delay_r) && $stable(line_r))
      else $error("query changed a setting");

endmodule

`default_nettype wire

// ==== test/far_unit.sv ====
// Purpose: Far-side lead unit: start pins and link clock bursts
// Assumes: Bench requests pulses on go and bursts on burst
// Notes: Link clock stands still outside bursts

`timescale 1ns/10ps
`default_nettype none

module far_unit (
   // Requests
   input wire logic aclk,
   input wire logic [1:0] go,
   input wire logic burst,
   input wire logic [3:0] n_clk,
   // Pins
   output logic clk_line,
   output logic start_line,
   output logic lbus_line
);
   initial begin
      clk_line = 1'b0;
      start_line = 1'b0;
      lbus_line = 1'b0;
   end
   // Start pulse held four cycles on the chosen line
   always @(posedge aclk) begin
      if (go != 2'b00) begin
         start_line <= go[0];
         lbus_line <= go[1];
         repeat (4) @(posedge aclk);
         start_line <= 1'b0;
         lbus_line <= 1'b0;
      end
   end
   // Burst of 80 ns link clock periods, phase off the bench clock
   always @(posedge burst) begin
      #3;
      repeat (n_clk) begin
         clk_line = 1'b1;
         #40;
         clk_line = 1'b0;
         #40;
      end
   end
endmodule

`default_nettype wire

// ==== test/multi_unit_sync_coupling_tb.sv ====
// Purpose: Self-checking bench for the coupling block
// Assumes: TICK_CNT of 4, register reads compared from a queue
// Notes: Start latencies are checked against a window

`timescale 1ns/10ps
`default_nettype none

module multi_unit_sync_coupling_tb;
   import coupling_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, start_req = 0, continuous_mode = 0;
   logic ref_clk_lvl = 0, lan_mode = 0, burst = 0;
   logic rate = 0, combo = 1, r_e = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, ip;
   logic [3:0] wstrb = 4'hF, n_clk = 0;
   logic [1:0] bresp, rresp, ecl_out, ecl_oe, go = 0;
   logic awready, wready, bvalid, arready, rvalid, wave_start;
   logic link_clk_tick, neighbour_out, neighbour_oe, lbus_out, lbus_oe;
   logic clk_line, start_line, lbus_line, c_e = 0, f_e = 0, l_e = 0;
   logic [19:0] codes[4] = '{CODE_ROLE, CODE_DELAY, CODE_COUPLE, CODE_PATH};
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int lo_q[$], hi_q[$];
   int n_mismatch = 0, checks = 0, cyc = 0, t0 = 0, ticks = 0, d;

   multi_unit_sync_coupling #(.TICK_CNT(4)) DUT (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .start_req,
      .continuous_mode, .ref_clk_lvl, .rate_above_66m(rate), .wave_start,
      .link_clk_tick, .ecl_in({start_line, clk_line}), .ecl_out, .ecl_oe,
      .neighbour_in(start_line), .neighbour_out, .neighbour_oe,
      .lbus_in(lbus_line), .lbus_out, .lbus_oe,
      .carrier_combo_ok(combo), .lan_mode);
   far_unit far (.aclk, .go, .burst, .n_clk, .clk_line, .start_line,
      .lbus_line);

   always #2.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_mismatch++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bq.push_back((a inside {OFS_ARG0, OFS_ARG1, OFS_CMD, OFS_STATUS}) ?
         RESP_OKAY : RESP_SLVERR);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(negedge aclk); while (awready !== 1'b1);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(negedge aclk); while (bvalid !== 1'b1);
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] exp);
      rq.push_back(exp);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge aclk); while (rvalid !== 1'b1);
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task automatic cmd(input logic [19:0] c, input logic [31:0] a, logic q);
      wr(OFS_ARG0, a);
      wr(OFS_CMD, {q, 11'h000, c});
   endtask

   task automatic qry(input logic [19:0] c, input logic [31:0] a,
                      input logic [31:0] exp);
      cmd(c, a, 1'b1);
      rd(OFS_RESP, {2'b00, exp});
   endtask

   task automatic st(input logic e);
      rd(OFS_STATUS, {28'h0000000, f_e, l_e, r_e, 1'b0, c_e, e});
      if (e) wr(OFS_STATUS, 32'h1);
   endtask

   task automatic fire(input logic [1:0] g, input int lo, input int hi);
      lo_q.push_back(lo);
      hi_q.push_back(hi);
      t0 = cyc;
      if (g == 2'b00) start_req <= 1'b1;
      else go <= g;
      @(posedge aclk);
      start_req <= 1'b0;
      go <= 2'b00;
      repeat (hi + 4) @(posedge aclk);
   endtask

   // Result watcher: register reads and start pulses
   always @(negedge aclk) begin
      int lat, lo, hi;
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
      if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
      if (wave_start) begin
         chk(34'({ecl_out[1], neighbour_out, lbus_out}),
            34'({3{!f_e}}));
         lat = cyc - t0;
         lo = lo_q.pop_front();
         hi = hi_q.pop_front();
         chk(34'(lat >= lo && lat <= hi), 34'h1);
      end
      if (link_clk_tick) ticks++;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(22533));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (codes[i]) qry(codes[i], 32'h0, 32'h0);
      for (int i = 0; i < 2; i++) qry(CODE_LINE, i << 8, i << 8);
      chk(34'({ecl_oe, lbus_oe, neighbour_oe}), 34'h0);
      for (int p = 0; p < 3; p++) begin
         cmd(CODE_PATH, p, 1'b0);
         qry(CODE_PATH, 32'h0, p);
         st(1'b0);
      end
      cmd(CODE_PATH, 32'h3, 1'b0);
      st(1'b1);
      qry(CODE_PATH, 32'h0, 32'h2);
      cmd(CODE_PATH, 32'h1, 1'b0);
      cmd(CODE_COUPLE, 32'h1, 1'b0);
      c_e = 1'b1;
      qry(CODE_COUPLE, 32'h0, 32'h1);
      chk(34'({ecl_oe, lbus_oe, neighbour_oe}), 34'hC);
      rate <= 1'b1;
      r_e = 1'b1;
      st(1'b0);
      rate <= 1'b0;
      r_e = 1'b0;
      fire(2'b00, 2, 2);
      cmd(CODE_PATH, 32'h0, 1'b0);
      chk(34'({ecl_oe, lbus_oe, neighbour_oe}), 34'h1);
      combo <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(34'(neighbour_oe), 34'h0);
      combo <= 1'b1;
      cmd(CODE_PATH, 32'h2, 1'b0);
      chk(34'({ecl_oe, lbus_oe, neighbour_oe}), 34'h2);
      cmd(CODE_PATH, 32'h1, 1'b0);
      cmd(CODE_COUPLE, 32'h0, 1'b0);
      c_e = 1'b0;
      cmd(CODE_LINE, 32'h0101, 1'b0);
      qry(CODE_LINE, 32'h0100, 32'h0101);
      qry(CODE_LINE, 32'h0000, 32'h0000);
      ref_clk_lvl <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(34'({ecl_oe, ecl_out[0]}), 34'h5);
      cmd(CODE_LINE, 32'h0201, 1'b0);
      st(1'b1);
      cmd(CODE_LINE, 32'h0100, 1'b0);
      cmd(CODE_BYPASS, 32'h1, 1'b0);
      st(1'b1);
      cmd(CODE_BYPASS, 32'h0, 1'b1);
      st(1'b1);
      cmd(CODE_DELAY, DELAY_MAX, 1'b0);
      cmd(CODE_DELAY, DELAY_MAX + 1, 1'b0);
      st(1'b1);
      qry(CODE_DELAY, 32'h0, DELAY_MAX);
      cmd(CODE_ROLE, 32'h1, 1'b0);
      f_e = 1'b1;
      d = $urandom_range(8, 1);
      cmd(CODE_DELAY, d, 1'b0);
      continuous_mode <= 1'b1;
      fire(2'b01, d * 4 + 3, d * 4 + 10);
      continuous_mode <= 1'b0;
      fire(2'b01, 3, 10);
      cmd(CODE_PATH, 32'h2, 1'b0);
      fire(2'b10, 3, 10);
      cmd(CODE_PATH, 32'h0, 1'b0);
      fire(2'b01, 3, 10);
      ip = $urandom;
      cmd(CODE_LIST_INS, ip, 1'b0);
      st(1'b1);
      lan_mode <= 1'b1;
      l_e = 1'b1;
      repeat (4) @(posedge aclk);
      wr(OFS_ARG1, $urandom);
      cmd(CODE_LIST_INS, ip, 1'b0);
      rd(OFS_RESP, {2'b00, 24'h000000, DESIG_BASE});
      st(1'b0);
      cmd(CODE_LIST_DEL, ~ip, 1'b0);
      st(1'b1);
      cmd(CODE_LIST_DEL, ip, 1'b0);
      st(1'b0);
      cmd(CODE_LIST_DEL, ip, 1'b0);
      st(1'b1);
      rd(8'h20, {RESP_SLVERR, 32'h0});
      wr(8'h20, 32'h0);
      n_clk <= 4'h5;
      burst <= 1'b1;
      repeat (100) @(posedge aclk);
      chk(34'(ticks), 34'h5);
      chk(34'(lo_q.size() + bq.size()), 34'h0);
      conclude();
   end
endmodule

`default_nettype wire
